//--- include/regmap_pkg.sv
/*
 * Shared constants and types of the register access front end: selector
 * codes, register addresses, field positions, reset values and the request
 * carrier that the link side hands to the core side.
 * Assumes the SPI framing layer outside delivers one decoded request at a time.
 */
package regmap_pkg;

    // ---------------------------------------------------------------
    // Memory map selectors
    // ---------------------------------------------------------------
    localparam logic [3:0] MMS_STD = 4'h0;
    localparam logic [3:0] MMS_MAC = 4'h1;
    localparam logic [3:0] MMS_PCS = 4'h2;
    localparam logic [3:0] MMS_PMA = 4'h3;
    localparam logic [3:0] MMS_PLCA = 4'h4;
    localparam logic [3:0] MMS_VEND = 4'hC;
    localparam int NUM_SEL16 = 4;

    // ---------------------------------------------------------------
    // Register addresses within their selector
    // ---------------------------------------------------------------
    localparam logic [15:0] ADDR_VERSION = 16'h0000;
    localparam logic [15:0] ADDR_PHY_IDENTIFIER = 16'h0001;
    localparam logic [15:0] ADDR_STANDARD_CAPABILITIES = 16'h0002;
    localparam logic [15:0] ADDR_RESETCTL = 16'h0003;
    localparam logic [15:0] ADDR_BOOTCTL = 16'h0010;
    localparam logic [15:0] ADDR_EVSTAT = 16'h0011;
    localparam logic [15:0] ADDR_RDCLR = 16'h0012;
    localparam logic [15:0] ADDR_LOCK = 16'h0013;
    localparam logic [15:0] ADDR_MACCTL = 16'h0000;
    localparam logic [15:0] ADDR_REG16 = 16'h0000;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int RST_SOFT_BIT = 0;
    localparam int BOOT_ISO_BIT = 0;
    localparam int BOOT_STRAP_BIT = 1;
    localparam int LOCK_BIT = 0;
    localparam int EV_W = 6;
    localparam int EV_COR = 0;
    localparam int EV_COAW = 1;
    localparam int EV_CW1 = 2;
    localparam int EV_CW0 = 3;
    localparam int EV_LH = 4;
    localparam int EV_LL = 5;

    // ---------------------------------------------------------------
    // Reset values and timing
    // ---------------------------------------------------------------
    localparam logic [EV_W-1:0] EV_RST = 6'h20;
    localparam logic [31:0] MACCTL_RST = 32'h0000_0000;
    localparam logic [31:0] RDCLR_RST = 32'h0000_0000;
    localparam logic [31:0] LOCK_RST = 32'h0000_0000;
    localparam logic [15:0] REG16_RST = 16'h0000;
    localparam logic STRAP_NORMAL = 1'b0;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    typedef struct packed {
        logic write;
        logic [3:0] memory_map_selector;
        logic [15:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef enum logic [1:0] {
        LINK_IDLE = 2'b01,
        LINK_WAIT = 2'b10
    } link_state_t;

endpackage

//--- verilog/register_map_access_boot.sv
/*
 * Register access front end: boot strap capture with isolated mode, register
 * decode by selector and address, 16-bit group handling and per-field access
 * behaviour. Requests arrive on the link clock and are served on clk.
 * Assumes the framing layer issues a request only while link_busy is low and
 * that event_in and op_done come from logic on clk.
 */
// How it works
// RL1: strap low at boot selects normal mode
// RL2: isolated strap keeps pins undriven until cleared
// RL3: register traffic keeps working while isolated
// RL4: selector 0 standard, selector 1 MAC, 32-bit
// RL5: selectors 2,3,4,12 hold 16-bit registers
// RL6: selector plus 16-bit address decode uniquely
// RL7: 16-bit reads return zero upper half
// RL8: 16-bit writes drop the upper half
// RL9: lock value written blocks later writes
// RL10: read-only fields ignore writes, constants fixed
// RL11: clear-on-read field clears after read
// RL12: any write clears the clear-on-write field
// RL13: matching written bit clears value-clear field
// RL14: read-write field clears after any read
// RL15: command bit holds until operation done
// RL16: latch-high holds one until read
// RL17: latch-low holds zero until read
// RL18: framing layer follows the serial protocol
// RL19: strap latched once after reset release
// RL20: unmapped addresses read zero, ignore writes
module register_map_access_boot #(
    parameter logic [31:0] VERSION_VALUE = 32'h0000_0012, // Arbitrary value
    parameter logic [31:0] PHY_ID_VALUE = 32'h1234_5670, // Arbitrary value
    parameter logic [31:0] STD_CAP_VALUE = 32'h0000_0000
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic link_clk,
    input wire logic link_reset_n,
    input wire logic boot_strap_pin,
    input wire logic link_req_valid,
    input wire regmap_pkg::reg_req_t link_req,
    output logic link_busy,
    output logic link_resp_valid,
    output logic [31:0] link_resp_data,
    input wire logic [regmap_pkg::EV_W-1:0] event_in,
    input wire logic op_done,
    output logic iface_pin_oe,
    output logic boot_isolated,
    output logic soft_reset_cmd,
    output logic [31:0] mac_control
);

    // ---------------------------------------------------------------
    // Link domain: take a request, hand it over, return the answer
    // ---------------------------------------------------------------
    regmap_pkg::link_state_t link_state_q, link_state_d;
    regmap_pkg::reg_req_t link_req_q, link_req_d;
    logic req_tgl_q, req_tgl_d;
    logic ack_s1_q, ack_s2_q, ack_seen_q, ack_seen_d;
    logic resp_valid_q, resp_valid_d, busy_q, busy_d;
    logic [31:0] resp_data_q, resp_data_d;
    logic ack_tgl_q;
    logic [31:0] rdata_q;

    always_comb begin
        link_state_d = link_state_q;
        link_req_d = link_req_q;
        req_tgl_d = req_tgl_q;
        ack_seen_d = ack_seen_q;
        resp_valid_d = 1'b0;
        resp_data_d = resp_data_q;
        case (link_state_q)
            regmap_pkg::LINK_IDLE: begin
                if (link_req_valid) begin
                    // Request word stays frozen until the answer returns
                    link_req_d = link_req; // see RL18
                    req_tgl_d = ~req_tgl_q;
                    link_state_d = regmap_pkg::LINK_WAIT;
                end
            end
            regmap_pkg::LINK_WAIT: begin
                if (ack_s2_q != ack_seen_q) begin
                    ack_seen_d = ack_s2_q;
                    resp_data_d = rdata_q;
                    resp_valid_d = 1'b1;
                    link_state_d = regmap_pkg::LINK_IDLE;
                end
            end
            default: begin
                link_state_d = regmap_pkg::LINK_IDLE;
            end
        endcase
        busy_d = (link_state_d == regmap_pkg::LINK_WAIT);
    end

    always_ff @(posedge link_clk or negedge link_reset_n) begin
        if (!link_reset_n) begin
            link_state_q <= regmap_pkg::LINK_IDLE;
            link_req_q <= '0;
            req_tgl_q <= 1'b0;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_seen_q <= 1'b0;
            resp_valid_q <= 1'b0;
            busy_q <= 1'b0;
            resp_data_q <= 32'h0000_0000;
        end else begin
            link_state_q <= link_state_d;
            link_req_q <= link_req_d;
            req_tgl_q <= req_tgl_d;
            ack_s1_q <= ack_tgl_q;
            ack_s2_q <= ack_s1_q;
            ack_seen_q <= ack_seen_d;
            resp_valid_q <= resp_valid_d;
            busy_q <= busy_d;
            resp_data_q <= resp_data_d;
        end
    end

    assign link_busy = busy_q;
    assign link_resp_valid = resp_valid_q;
    assign link_resp_data = resp_data_q;

    // ---------------------------------------------------------------
    // Boot strap capture
    // ---------------------------------------------------------------
    logic strap_s1_q, strap_s2_q;
    logic req_s1_q, req_s2_q;
    logic [1:0] boot_cnt_q, boot_cnt_d;
    logic boot_done_q, boot_done_d;
    logic strap_latched_q, strap_latched_d;

    always_comb begin
        boot_cnt_d = boot_cnt_q;
        boot_done_d = boot_done_q;
        strap_latched_d = strap_latched_q;
        // Wait for the synchroniser to fill before trusting the pin
        if (!boot_done_q) begin
            if (boot_cnt_q == regmap_pkg::STRAP_SETTLE) begin
                boot_done_d = 1'b1; // see RL19
                strap_latched_d = strap_s2_q; // see RL1
            end else begin
                boot_cnt_d = boot_cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_s1_q <= 1'b0;
            strap_s2_q <= 1'b0;
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            boot_cnt_q <= 2'h0;
            boot_done_q <= 1'b0;
            strap_latched_q <= regmap_pkg::STRAP_NORMAL;
        end else begin
            strap_s1_q <= boot_strap_pin;
            strap_s2_q <= strap_s1_q;
            req_s1_q <= req_tgl_q;
            req_s2_q <= req_s1_q;
            boot_cnt_q <= boot_cnt_d;
            boot_done_q <= boot_done_d;
            strap_latched_q <= strap_latched_d;
        end
    end

    // ---------------------------------------------------------------
    // Register core
    // ---------------------------------------------------------------
    localparam logic [3:0] SEL16 [regmap_pkg::NUM_SEL16] = '{
        regmap_pkg::MMS_PCS, regmap_pkg::MMS_PMA, regmap_pkg::MMS_PLCA, regmap_pkg::MMS_VEND
    };

    logic req_seen_q;
    logic fire;
    logic ack_tgl_d;
    logic [31:0] rdata_d;
    logic iso_q, iso_d;
    logic oe_q, oe_d;
    logic soft_q, soft_d;
    logic [regmap_pkg::EV_W-1:0] ev_q, ev_d;
    logic [31:0] mac_q, mac_d;
    logic [31:0] rdclr_q, rdclr_d;
    logic [31:0] lock_q, lock_d;
    logic [15:0] reg16_q [regmap_pkg::NUM_SEL16];
    logic [15:0] reg16_d [regmap_pkg::NUM_SEL16];
    logic [regmap_pkg::NUM_SEL16-1:0] sel16_hit;
    logic hit;
    logic is_wr, is_rd;
    logic [31:0] wd;
    logic [regmap_pkg::EV_W-1:0] ev_clr;

    assign fire = (req_s2_q != req_seen_q);
    assign is_wr = fire && link_req_q.write;
    assign is_rd = fire && !link_req_q.write;
    assign wd = link_req_q.wdata;

    // One 16-bit register per narrow selector
    genvar gi;
    generate
        for (gi = 0; gi < regmap_pkg::NUM_SEL16; gi++) begin : g_sel16
            assign sel16_hit[gi] = (link_req_q.memory_map_selector == SEL16[gi])
                && (link_req_q.addr == regmap_pkg::ADDR_REG16); // see RL5
            always_comb begin
                reg16_d[gi] = reg16_q[gi];
                if (is_wr && sel16_hit[gi]) begin
                    reg16_d[gi] = wd[15:0]; // see RL8
                end
            end
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    reg16_q[gi] <= regmap_pkg::REG16_RST;
                end else begin
                    reg16_q[gi] <= reg16_d[gi];
                end
            end
        end
    endgenerate

    always_comb begin
        rdata_d = rdata_q;
        ack_tgl_d = ack_tgl_q;
        hit = 1'b0;
        ev_clr = '0;
        iso_d = iso_q;
        soft_d = soft_q;
        mac_d = mac_q;
        rdclr_d = rdclr_q;
        lock_d = lock_q;
        if (fire) begin
            ack_tgl_d = ~ack_tgl_q; // see RL3
            rdata_d = 32'h0000_0000; // see RL20
            // Selector and address together pick one register
            if (link_req_q.memory_map_selector == regmap_pkg::MMS_STD) begin // see RL4, RL6
                if (link_req_q.addr == regmap_pkg::ADDR_VERSION) begin
                    hit = 1'b1;
                    rdata_d = VERSION_VALUE; // see RL10
                end else if (link_req_q.addr == regmap_pkg::ADDR_PHY_IDENTIFIER) begin
                    hit = 1'b1;
                    rdata_d = PHY_ID_VALUE; // see RL10
                end else if (link_req_q.addr == regmap_pkg::ADDR_STANDARD_CAPABILITIES) begin
                    hit = 1'b1;
                    rdata_d = STD_CAP_VALUE; // see RL10
                end else if (link_req_q.addr == regmap_pkg::ADDR_RESETCTL) begin
                    hit = 1'b1;
                    rdata_d[regmap_pkg::RST_SOFT_BIT] = soft_q;
                    if (is_wr && wd[regmap_pkg::RST_SOFT_BIT]) begin
                        soft_d = 1'b1; // see RL15
                    end
                end else if (link_req_q.addr == regmap_pkg::ADDR_BOOTCTL) begin
                    hit = 1'b1;
                    rdata_d[regmap_pkg::BOOT_ISO_BIT] = iso_q;
                    rdata_d[regmap_pkg::BOOT_STRAP_BIT] = strap_latched_q;
                    if (is_wr && wd[regmap_pkg::BOOT_ISO_BIT]) begin
                        iso_d = 1'b0; // see RL2, RL13
                    end
                end else if (link_req_q.addr == regmap_pkg::ADDR_EVSTAT) begin
                    hit = 1'b1;
                    rdata_d[regmap_pkg::EV_W-1:0] = ev_q;
                    if (is_rd) begin
                        ev_clr[regmap_pkg::EV_COR] = 1'b1; // see RL11
                        ev_clr[regmap_pkg::EV_LH] = 1'b1; // see RL16
                        ev_clr[regmap_pkg::EV_LL] = 1'b1; // see RL17
                    end else begin
                        ev_clr[regmap_pkg::EV_COAW] = 1'b1; // see RL12
                        ev_clr[regmap_pkg::EV_CW1] = wd[regmap_pkg::EV_CW1]; // see RL13
                        ev_clr[regmap_pkg::EV_CW0] = !wd[regmap_pkg::EV_CW0]; // see RL13
                    end
                end else if (link_req_q.addr == regmap_pkg::ADDR_RDCLR) begin
                    hit = 1'b1;
                    rdata_d = rdclr_q;
                    rdclr_d = is_rd ? regmap_pkg::RDCLR_RST : wd; // see RL14
                end else if (link_req_q.addr == regmap_pkg::ADDR_LOCK) begin
                    hit = 1'b1;
                    rdata_d = lock_q;
                    if (is_wr && !lock_q[regmap_pkg::LOCK_BIT]) begin
                        lock_d = wd; // see RL9
                    end
                end
            end else if (link_req_q.memory_map_selector == regmap_pkg::MMS_MAC) begin
                if (link_req_q.addr == regmap_pkg::ADDR_MACCTL) begin
                    hit = 1'b1;
                    rdata_d = mac_q;
                    if (is_wr) begin
                        mac_d = wd;
                    end
                end
            end else begin
                for (int i = 0; i < regmap_pkg::NUM_SEL16; i++) begin
                    if (sel16_hit[i]) begin
                        hit = 1'b1;
                        rdata_d = {16'h0000, reg16_q[i]}; // see RL7
                    end
                end
            end
        end
        // The operation finishing ends the command unless it is newly set from clear now
        if (op_done && soft_d == soft_q) begin
            soft_d = 1'b0; // see RL15
        end
        // Hardware events win over a clear in the same cycle
        ev_d = ev_q & ~ev_clr;
        ev_d[regmap_pkg::EV_LL] = ev_q[regmap_pkg::EV_LL] | ev_clr[regmap_pkg::EV_LL];
        for (int i = 0; i < regmap_pkg::EV_W; i++) begin
            if (event_in[i]) begin
                ev_d[i] = (i != regmap_pkg::EV_LL); // see RL16, RL17
            end
        end
        // Strap result lands once, when the boot capture completes
        if (boot_done_d && !boot_done_q) begin
            iso_d = strap_latched_d; // see RL2
        end
        oe_d = boot_done_d && !iso_d; // see RL1, RL2
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            req_seen_q <= 1'b0;
            ack_tgl_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            iso_q <= 1'b0;
            oe_q <= 1'b0;
            soft_q <= 1'b0;
            ev_q <= regmap_pkg::EV_RST;
            mac_q <= regmap_pkg::MACCTL_RST;
            rdclr_q <= regmap_pkg::RDCLR_RST;
            lock_q <= regmap_pkg::LOCK_RST;
        end else begin
            req_seen_q <= req_s2_q;
            ack_tgl_q <= ack_tgl_d;
            rdata_q <= rdata_d;
            iso_q <= iso_d;
            oe_q <= oe_d;
            soft_q <= soft_d;
            ev_q <= ev_d;
            mac_q <= mac_d;
            rdclr_q <= rdclr_d;
            lock_q <= lock_d;
        end
    end

    assign iface_pin_oe = oe_q;
    assign boot_isolated = iso_q;
    assign soft_reset_cmd = soft_q;
    assign mac_control = mac_q;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_STRAP_HELD: assert property (boot_done_q |=> $stable(strap_latched_q)) // see RL19
        else $error("boot strap changed after capture");
    AST_NORMAL_DRIVES: assert property ( // see RL1
        boot_done_q && !iso_q |=> oe_q)
        else $error("normal mode left the pins undriven");
    AST_ISO_HIZ: assert property ( // see RL2
        iso_q && !is_wr |=> !oe_q && iso_q)
        else $error("isolated mode released without a write");
    AST_ISO_SERVES: assert property ( // see RL3
        iso_q && fire |=> (ack_tgl_q != $past(ack_tgl_q)))
        else $error("request not answered in isolated mode");
    AST_UPPER_ZERO: assert property ( // see RL7
        is_rd && |sel16_hit |=> rdata_q[31:16] == 16'h0000)
        else $error("16-bit read returned nonzero upper half");
    AST_LOCK_HOLDS: assert property ( // see RL9
        lock_q[regmap_pkg::LOCK_BIT] |=> $stable(lock_q))
        else $error("locked register changed");
    AST_RO_CONST: assert property ( // see RL10
        fire && link_req_q.memory_map_selector == regmap_pkg::MMS_STD
        && link_req_q.addr == regmap_pkg::ADDR_VERSION |=> rdata_q == VERSION_VALUE)
        else $error("constant register read wrong");
    AST_COR_CLEARS: assert property ( // see RL11
        is_rd && link_req_q.memory_map_selector == regmap_pkg::MMS_STD
        && link_req_q.addr == regmap_pkg::ADDR_EVSTAT && !event_in[regmap_pkg::EV_COR]
        |=> !ev_q[regmap_pkg::EV_COR])
        else $error("clear-on-read field survived read");
    AST_LH_SETS: assert property ( // see RL16
        event_in[regmap_pkg::EV_LH] || (ev_q[regmap_pkg::EV_LH] && !is_rd)
        |=> ev_q[regmap_pkg::EV_LH])
        else $error("latch-high field dropped early");
    AST_SC_HOLDS: assert property ( // see RL15
        soft_q && !op_done |=> soft_q)
        else $error("command bit cleared before done");
    AST_UNMAPPED_ZERO: assert property ( // see RL20
        fire && !hit |=> rdata_q == 32'h0000_0000)
        else $error("unmapped read returned data");

    COV_ISOLATED_BOOT: cover property (boot_done_q && iso_q ##[1:200] !iso_q);
    COV_LOCK_SET: cover property (!lock_q[regmap_pkg::LOCK_BIT] ##1 lock_q[regmap_pkg::LOCK_BIT]);
    COV_SEL16_WRITE: cover property (is_wr && |sel16_hit);
    COV_EVENT_VS_READ: cover property (is_rd && event_in[regmap_pkg::EV_COR]);

endmodule // register_map_access_boot

//--- verification/host_model.sv
/*
 * Host side model: issues one register request at a time on the link side.
 * Assumes the block takes a request while link_busy is low and answers it
 * with a single link_resp_valid pulse.
 */
module host_model (
    input wire logic link_clk,
    input wire logic link_busy,
    input wire logic link_resp_valid,
    input wire logic [31:0] link_resp_data,
    output logic link_req_valid,
    output regmap_pkg::reg_req_t link_req
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        link_req_valid = 1'b0;
        link_req = '0;
    end

    // ------------------------------------------------------------
    // One transfer: request held for one taking edge, answer awaited
    // ------------------------------------------------------------
    task automatic access(input logic wr, input logic [3:0] memory_map_selector, input logic [15:0] addr,
        input logic [31:0] wdata, output logic [31:0] rdata, output logic ok,
        output logic [1:0] busy);
        int n;
        ok = 1'b0;
        busy = 2'b11;
        rdata = '0;
        @(posedge link_clk);
        #1;
        link_req_valid = 1'b1;
        link_req = '{write: wr, memory_map_selector: memory_map_selector, addr: addr, wdata: wdata};
        // Previous answer already seen, so busy is low and this edge takes it
        @(posedge link_clk);
        #1;
        link_req_valid = 1'b0;
        busy[1] = link_busy;
        // Released fields toggle so nothing can lean on stale values
        link_req = ~link_req;
        for (n = 0; n < 60 && !ok; n++) begin
            @(posedge link_clk);
            #0.5;
            if (link_resp_valid === 1'b1) begin
                ok = 1'b1;
                rdata = link_resp_data;
                busy[0] = link_busy;
            end
        end
    endtask
endmodule // host_model

//--- verification/tb.sv
/*
 * Self-checking bench of the register access front end.
 * Assumes the design and host_model are compiled first.
 */
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic reset_n = 1'b0;
    logic link_reset_n = 1'b0;
    logic boot_strap_pin = 1'b0;
    logic link_req_valid, link_busy, link_resp_valid, op_done = 1'b0;
    regmap_pkg::reg_req_t link_req;
    logic [31:0] link_resp_data, mac_control, r, v;
    logic [regmap_pkg::EV_W-1:0] event_in = '0;
    logic iface_pin_oe, boot_isolated, soft_reset_cmd;
    logic [31:0] lfsr_q = 32'h0000_4ded;
    logic [3:0] sel16 [4] = '{4'h2, 4'h3, 4'h4, 4'hC};
    logic [3:0] unmap [4] = '{4'h0, 4'h1, 4'h5, 4'hD};
    int errors = 0;
    int compares = 0;
    localparam logic [31:0] VER = 32'h0000_5a01; // Arbitrary value
    localparam logic [31:0] PID = 32'h0bad_c0d0; // Arbitrary value
    localparam logic [31:0] CAP = 32'h0000_0123;

    always #4 clk = ~clk;
    always #3 link_clk = ~link_clk;

    register_map_access_boot #(.VERSION_VALUE(VER), .PHY_ID_VALUE(PID), .STD_CAP_VALUE(CAP)) dut (
        .clk(clk), .reset_n(reset_n), .link_clk(link_clk), .link_reset_n(link_reset_n),
        .boot_strap_pin(boot_strap_pin), .link_req_valid(link_req_valid),
        .link_req(link_req), .link_busy(link_busy), .link_resp_valid(link_resp_valid),
        .link_resp_data(link_resp_data), .event_in(event_in), .op_done(op_done),
        .iface_pin_oe(iface_pin_oe), .boot_isolated(boot_isolated),
        .soft_reset_cmd(soft_reset_cmd), .mac_control(mac_control));

    host_model host (.link_clk(link_clk), .link_busy(link_busy),
        .link_resp_valid(link_resp_valid), .link_resp_data(link_resp_data),
        .link_req_valid(link_req_valid), .link_req(link_req));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] next_rand();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q;
    endfunction

    task automatic final_report();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic acc(input logic wr, input logic [3:0] m, input logic [15:0] a,
        input logic [31:0] w, output logic [31:0] rd);
        logic ok;
        logic [1:0] busy;
        host.access(wr, m, a, w, rd, ok, busy);
        check("answer", 32'(ok), 32'h0000_0001);
        if (!ok) final_report();
        check("busy", 32'(busy), 32'h0000_0002);
    endtask

    task automatic rd_chk(input string name, input logic [3:0] m, input logic [15:0] a,
        input logic [31:0] exp);
        logic [31:0] rd;
        acc(1'b0, m, a, '0, rd);
        check(name, rd, exp);
    endtask

    task automatic wr(input logic [3:0] m, input logic [15:0] a, input logic [31:0] w);
        logic [31:0] rd;
        acc(1'b1, m, a, w, rd);
    endtask

    task automatic clk_pulse(input logic [regmap_pkg::EV_W-1:0] ev, input logic done);
        @(posedge clk);
        #1;
        event_in = ev;
        op_done = done;
        @(posedge clk);
        #1;
        event_in = '0;
        op_done = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic do_reset(input logic strap);
        @(posedge clk);
        #1;
        reset_n = 1'b0;
        link_reset_n = 1'b0;
        boot_strap_pin = strap;
        repeat (16) @(posedge clk);
        check("oe in reset", 32'(iface_pin_oe), 32'h0000_0000);
        #1;
        reset_n = 1'b1;
        link_reset_n = 1'b1;
        repeat (10) @(posedge clk);
        #1;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        do_reset(1'b0);
        check("oe", 32'(iface_pin_oe), 32'h0000_0001);
        check("iso", 32'(boot_isolated), 32'h0000_0000);
        rd_chk("boot", 4'h0, regmap_pkg::ADDR_BOOTCTL, 32'h0000_0000);
        $display("test boot normal done");
        for (int i = 0; i < 2; i++) begin
            rd_chk("ver", 4'h0, regmap_pkg::ADDR_VERSION, VER);
            rd_chk("pid", 4'h0, regmap_pkg::ADDR_PHY_IDENTIFIER, PID);
            rd_chk("cap", 4'h0, regmap_pkg::ADDR_STANDARD_CAPABILITIES, CAP);
            wr(4'h0, regmap_pkg::ADDR_VERSION, next_rand());
            wr(4'h0, regmap_pkg::ADDR_PHY_IDENTIFIER, next_rand());
            wr(4'h0, regmap_pkg::ADDR_STANDARD_CAPABILITIES, next_rand());
        end
        for (int i = 0; i < 4; i++) begin
            r = next_rand();
            wr(regmap_pkg::MMS_MAC, regmap_pkg::ADDR_MACCTL, r);
            rd_chk("mac", regmap_pkg::MMS_MAC, regmap_pkg::ADDR_MACCTL, r);
            check("mac port", mac_control, r);
        end
        foreach (sel16[i]) begin
            r = next_rand();
            wr(sel16[i], regmap_pkg::ADDR_REG16, r);
            rd_chk("reg16", sel16[i], regmap_pkg::ADDR_REG16, {16'h0000, r[15:0]});
        end
        foreach (sel16[i]) rd_chk("sel16 other", sel16[i], 16'h0001, 32'h0000_0000);
        foreach (unmap[i]) begin
            v = 32'h0000_0100 | (next_rand() & 32'h0000_00ff);
            wr(unmap[i], v[15:0], next_rand());
            rd_chk("unmapped", unmap[i], v[15:0], 32'h0000_0000);
        end
        $display("test map done");
        r = next_rand();
        wr(4'h0, regmap_pkg::ADDR_RDCLR, r);
        rd_chk("rdclr", 4'h0, regmap_pkg::ADDR_RDCLR, r);
        rd_chk("rdclr again", 4'h0, regmap_pkg::ADDR_RDCLR, 32'h0000_0000);
        r = next_rand() | 32'h0000_0001;
        wr(4'h0, regmap_pkg::ADDR_LOCK, r);
        wr(4'h0, regmap_pkg::ADDR_LOCK, ~r);
        rd_chk("lock", 4'h0, regmap_pkg::ADDR_LOCK, r);
        rd_chk("ev rst", 4'h0, regmap_pkg::ADDR_EVSTAT, 32'h0000_0020);
        clk_pulse(6'h3f, 1'b0);
        rd_chk("ev set", 4'h0, regmap_pkg::ADDR_EVSTAT, 32'h0000_001f);
        rd_chk("ev read", 4'h0, regmap_pkg::ADDR_EVSTAT, 32'h0000_002e);
        wr(4'h0, regmap_pkg::ADDR_EVSTAT, 32'h0000_0000);
        rd_chk("ev w0", 4'h0, regmap_pkg::ADDR_EVSTAT, 32'h0000_0024);
        wr(4'h0, regmap_pkg::ADDR_EVSTAT, 32'h0000_0004);
        rd_chk("ev w1", 4'h0, regmap_pkg::ADDR_EVSTAT, 32'h0000_0020);
        $display("test fields done");
        wr(4'h0, regmap_pkg::ADDR_RESETCTL, 32'h0000_0001);
        check("cmd set", 32'(soft_reset_cmd), 32'h0000_0001);
        rd_chk("cmd read", 4'h0, regmap_pkg::ADDR_RESETCTL, 32'h0000_0001);
        clk_pulse('0, 1'b1);
        check("cmd done", 32'(soft_reset_cmd), 32'h0000_0000);
        boot_strap_pin = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        check("late strap", 32'(boot_isolated), 32'h0000_0000);
        $display("test command done");
        do_reset(1'b1);
        check("iso oe", 32'(iface_pin_oe), 32'h0000_0000);
        rd_chk("iso boot", 4'h0, regmap_pkg::ADDR_BOOTCTL, 32'h0000_0003);
        wr(4'h0, regmap_pkg::ADDR_BOOTCTL, 32'h0000_0001);
        for (int n = 0; n < 20 && iface_pin_oe !== 1'b1; n++) @(posedge clk);
        check("released oe", 32'(iface_pin_oe), 32'h0000_0001);
        boot_strap_pin = 1'b0;
        repeat (10) @(posedge clk);
        rd_chk("boot after", 4'h0, regmap_pkg::ADDR_BOOTCTL, 32'h0000_0002);
        $display("test isolated done");
        final_report();
    end
endmodule // tb
